// File: hdl/conditional_branch_eval.sv
// Conditional relative branch evaluator for an 8-bit core.
// Assumes decode presents one branch per issue pulse with the current pc and the
// status flags steady; the core holds off the next issue while busy is high.
//
// Overview of operation
// - Lower branch jumps to pc plus offset plus one when carry is set; flags kept.
// - Minus branch jumps to pc plus offset plus one only when negative is set.
// - Plus branch jumps to pc plus offset plus one only when negative is clear.
// - Signed greater-or-equal jumps when negative xor overflow is zero; flags kept.
// - Signed less-than jumps when negative xor overflow is one, else falls through.
// - Half-carry-set branch jumps when half carry is one, in two cycles.
// - Half-carry-clear branch jumps when half carry is zero; flags untouched.
// - Transfer-set branch jumps when transfer flag is one, else proceeds.
module conditional_branch_eval #(
   parameter int PC_W  = branch_eval_pkg::PC_WIDTH,
   parameter int OFF_W = branch_eval_pkg::OFFSET_WIDTH
) (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        rst_b,
   // Decoded instruction
   input  wire logic                        issue,
   input  wire branch_eval_pkg::branch_op_t op,
   input  wire logic [OFF_W-1:0]            branch_offset,
   input  wire logic [PC_W-1:0]             pc,
   // Status flags, read only
   input  wire logic                        carry_flag,
   input  wire logic                        negative_flag,
   input  wire logic                        overflow_flag,
   input  wire logic                        half_carry_flag,
   input  wire logic                        transfer_flag,
   // Program counter update
   output logic                             pc_load,
   output logic [PC_W-1:0]                  next_pc,
   output logic                             busy,
   output logic                             done
);

   // Reset copy
   logic                           rst_sync1;
   logic                           rst_sync2;

   // Sequencer decode
   branch_eval_pkg::branch_state_t state;
   logic                           idle;
   logic                           second_cycle;

   // Branch decision
   logic                           accept;
   logic                           cond_true;
   logic                           taken;
   logic                           fall_through;

   // Target arithmetic
   logic [PC_W-1:0]                offset_ext;
   logic [PC_W-1:0]                target;

   // Reset is released synchronously so no flop leaves reset on a different edge.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync1 <= 1'h0;
      end else begin
         rst_sync1 <= 1'h1;
      end
   end

   // Only this flop reads the first stage, which may still be settling.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync2 <= 1'h0;
      end else begin
         rst_sync2 <= rst_sync1;
      end
   end

   // Signed comparison outcome from the negative and overflow flags.
   function automatic logic signed_less(input logic n,
                                        input logic v);
      logic r;
      r = n ^ v;
      return r;
   endfunction

   // The offset is sign-extended so backward branches subtract.
   function automatic logic [PC_W-1:0] sign_extend(input logic [OFF_W-1:0] k);
      logic [PC_W-1:0] r;
      r = PC_W'($signed(k));
      return r;
   endfunction

   // The sum wraps within the program space; no carry out is reported.
   function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] p,
                                                  input logic [PC_W-1:0] k);
      logic [PC_W-1:0] r;
      r = p + k + PC_W'(branch_eval_pkg::PC_STEP);
      return r;
   endfunction

   // Flag test for each branch; flags are only read, never written.
   function automatic logic cond_met(input branch_eval_pkg::branch_op_t o,
                                     input logic                        c,
                                     input logic                        n,
                                     input logic                        v,
                                     input logic                        h,
                                     input logic                        t);
      logic r;
      r = 1'h0;
      unique case (o)
         branch_eval_pkg::branch_if_lower: begin
            r = c;
         end
         branch_eval_pkg::branch_if_minus: begin
            r = n;
         end
         branch_eval_pkg::branch_if_plus: begin
            r = !n;
         end
         branch_eval_pkg::branch_if_signed_ge: begin
            r = !signed_less(n, v);
         end
         branch_eval_pkg::branch_if_signed_lt: begin
            r = signed_less(n, v);
         end
         branch_eval_pkg::branch_if_halfcarry_set: begin
            r = h;
         end
         branch_eval_pkg::branch_if_halfcarry_clear: begin
            r = !h;
         end
         branch_eval_pkg::branch_if_transfer_set: begin
            r = t;
         end
      endcase
      return r;
   endfunction

   always_comb begin
      idle = (state == branch_eval_pkg::st_idle);
   end

   always_comb begin
      second_cycle = (state == branch_eval_pkg::st_taken);
   end

   // Issue is refused in the second cycle of a taken branch and while reset holds.
   always_comb begin
      accept = issue && idle && rst_sync2;
   end

   always_comb begin
      cond_true = cond_met(op, carry_flag, negative_flag, overflow_flag,
                           half_carry_flag, transfer_flag);
   end

   always_comb begin
      taken = accept && cond_true;
   end

   always_comb begin
      fall_through = accept && !cond_true;
   end

   always_comb begin
      offset_ext = sign_extend(branch_offset);
   end

   always_comb begin
      target = rel_target(pc, offset_ext);
   end

   // A taken branch spends a second cycle while fetch refills.
   always_ff @(posedge ref_clk or negedge rst_sync2) begin
      if (!rst_sync2) begin
         state <= branch_eval_pkg::st_idle;
      end else begin
         unique case (state)
            branch_eval_pkg::st_idle: begin
               if (taken) begin
                  state <= branch_eval_pkg::st_taken;
               end else begin
                  state <= branch_eval_pkg::st_idle;
               end
            end
            branch_eval_pkg::st_taken: begin
               state <= branch_eval_pkg::st_idle;
            end
            // An illegal code would otherwise lock the sequencer.
            default: begin
               state <= branch_eval_pkg::st_idle;
            end
         endcase
      end
   end

   // The load strobe is registered so fetch sees a clean one-cycle pulse.
   always_ff @(posedge ref_clk or negedge rst_sync2) begin
      if (!rst_sync2) begin
         pc_load <= 1'h0;
      end else begin
         pc_load <= taken;
      end
   end

   // No flag output exists, so the status flags cannot be changed here.
   always_ff @(posedge ref_clk or negedge rst_sync2) begin
      if (!rst_sync2) begin
         next_pc <= PC_W'(branch_eval_pkg::PC_RESET);
      end else if (taken) begin
         next_pc <= target;
      end
   end

   // Busy is combinational so decode can hold off the very next issue.
   always_comb begin
      busy = taken || second_cycle;
   end

   // Done marks completion: same cycle for fall-through, second cycle if taken.
   always_comb begin
      done = fall_through || second_cycle;
   end

endmodule

// File: hdl/branch_eval_pkg.sv
// Constants and types shared by the conditional branch evaluator.
// Assumes a 16-bit word program counter and a 7-bit signed relative offset.
package branch_eval_pkg;

   localparam int PC_WIDTH     = 16;
   localparam int OFFSET_WIDTH = 7;

   // Opcode select for the branch group.
   typedef enum logic [2:0] {
      branch_if_lower           = 3'h0,
      branch_if_minus           = 3'h1,
      branch_if_plus            = 3'h2,
      branch_if_signed_ge       = 3'h3,
      branch_if_signed_lt       = 3'h4,
      branch_if_halfcarry_set   = 3'h5,
      branch_if_halfcarry_clear = 3'h6,
      branch_if_transfer_set    = 3'h7
   } branch_op_t;

   // Sequencer states, one-hot.
   typedef enum logic [1:0] {
      st_idle  = 2'h1,
      st_taken = 2'h2
   } branch_state_t;

   localparam logic [PC_WIDTH-1:0] PC_RESET = 16'h0000;
   localparam logic [PC_WIDTH-1:0] PC_STEP  = 16'h0001;

endpackage

// File: verification/branch_eval_assertions.sv
// Checker bound to the ports of the branch evaluator.
// Assumes issue stays low until the internal reset copy is released.
module branch_eval_assertions #(
   parameter int PC_W  = branch_eval_pkg::PC_WIDTH,
   parameter int OFF_W = branch_eval_pkg::OFFSET_WIDTH
) (
   // Clock and reset
   input logic                        ref_clk,
   input logic                        rst_b,
   // Decoded instruction
   input logic                        issue,
   input branch_eval_pkg::branch_op_t op,
   input logic [OFF_W-1:0]            branch_offset,
   input logic [PC_W-1:0]             pc,
   // Status flags
   input logic                        carry_flag,
   input logic                        negative_flag,
   input logic                        overflow_flag,
   input logic                        half_carry_flag,
   input logic                        transfer_flag,
   // Program counter update
   input logic                        pc_load,
   input logic [PC_W-1:0]             next_pc,
   input logic                        busy,
   input logic                        done
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire g = issue && !pc_load;
   chk_lower_out: assert property (g && op == 3'h0 |=> pc_load == $past(carry_flag))
      else $error("lower branch outcome");
   chk_sign_out: assert property (g && op inside {3'h1, 3'h2}
      |=> pc_load == $past(negative_flag ^ (op == 3'h2))) else $error("sign outcome");
   chk_signed_out: assert property (g && op inside {3'h3, 3'h4}
      |=> pc_load == $past(negative_flag ^ overflow_flag ^ (op == 3'h3))) else $error("ge lt");
   chk_half_out: assert property (g && op inside {3'h5, 3'h6}
      |=> pc_load == $past(half_carry_flag ^ (op == 3'h6))) else $error("half carry");
   chk_tflag_out: assert property (g && op == 3'h7
      |=> pc_load == $past(transfer_flag)) else $error("transfer outcome");
   chk_target_pc: assert property (g && busy
      |=> next_pc == $past(pc + {{(PC_W-OFF_W){branch_offset[OFF_W-1]}}, branch_offset}
                           + 16'h0001)) else $error("target");
   chk_fall_thru: assert property (g && !busy |-> done ##1 !pc_load) else $error("fall");
   chk_taken_two: assert property (g && busy |-> !done ##1 done && busy && pc_load)
      else $error("taken timing");
   chk_load_pulse: assert property (pc_load |=> !pc_load)
      else $error("load pulse");
   chk_target_hold: assert property (!pc_load |-> $stable(next_pc))
      else $error("target hold");
   chk_quiet_idle: assert property (!issue && !pc_load |-> !busy && !done)
      else $error("quiet idle");
endmodule
bind conditional_branch_eval branch_eval_assertions #(.PC_W(PC_W), .OFF_W(OFF_W)) i_chk (.*);

// File: verification/pc_model.sv
// Fetch model: steps the pc on a fall-through, loads it on a taken branch.
// Starts near the top of the space so that forward branches wrap.
module pc_model (
   // Clock and reset
   input  logic        ref_clk,
   input  logic        rst_b,
   // Branch outcome
   input  logic        pc_load,
   input  logic        done,
   input  logic [15:0] next_pc,
   // Current program counter
   output logic [15:0] pc
);
   timeunit 1ns;
   timeprecision 1ns;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pc <= 16'hffc0;
      end else if (pc_load) begin
         pc <= next_pc;
      end else if (done) begin
         pc <= pc + 16'h0001;
      end
   end
endmodule

// File: verification/testbench.sv
// Self-checking bench: every op with every flag pattern, then random branches.
// Assumes the design, its package, the checker and the fetch model are compiled first.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t: outputs differ", $time); end end
   logic ref_clk = 0, rst_b = 0, issue = 0, pc_load, busy, done, carry_flag = 0;
   logic negative_flag = 0, overflow_flag = 0, half_carry_flag = 0, transfer_flag = 0;
   logic [6:0] branch_offset = 7'h00;
   logic [15:0] pc, next_pc;
   branch_eval_pkg::branch_op_t op = branch_eval_pkg::branch_if_lower;
   int miscompares = 0, num_checks = 0;
   conditional_branch_eval i_conditional_branch_eval (.*);
   pc_model i_pc_model (.*);
   // A raised issue in the second cycle of a taken branch must be ignored.
   task automatic run(logic [2:0] o, logic [4:0] f, logic [6:0] k, logic r);
      logic [7:0] m = {f[4], !f[3], f[3], ^f[2:1], !(^f[2:1]), !f[1], f[1], f[0]};
      @(negedge ref_clk) op = branch_eval_pkg::branch_op_t'(o);
      {transfer_flag, half_carry_flag, overflow_flag, negative_flag, carry_flag} = f;
      {issue, branch_offset} = {1'h1, k};
      #10 `CHK({busy, done}, {m[o], !m[o]})
      if (m[o]) begin
         @(negedge ref_clk) issue = r;
         #10 `CHK({pc_load, done, busy, next_pc}, {3'h7, pc + {{9{k[6]}}, k} + 16'h0001})
      end
   endtask
   task automatic results();
      $display("checks %0d, miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial forever #50 ref_clk = ~ref_clk;
   initial begin
      void'($urandom(17));
      repeat (3) @(negedge ref_clk);
      rst_b = 1;
      repeat (2) @(negedge ref_clk);
      for (int i = 0; i < 256; i++) run(3'(i), 5'(i >> 3), i[1] ? 7'h40 : 7'h3f, i[0]);
      $display("corner test done");
      for (int i = 0; i < 300; i++) run(3'($urandom), 5'($urandom), 7'($urandom), 1'($urandom));
      $display("random test done");
      results();
   end
endmodule
